// >>> hw/ptp_pkg.sv
// package of constants and carriers for the precision-time receive classifier and stamp inserter
`default_nettype none
package ptp_pkg;
	localparam int unsigned MIN_MSG_LEN = 36;
	localparam logic [5:0] STAMP_OFS = 6'h22;
	localparam int unsigned STAMP_LEN = 10;
	localparam logic [5:0] V1_CTRL_OFS = 6'h20;
	localparam logic [5:0] V2_TYPE_OFS = 6'h00;
	localparam logic [5:0] VERSION_OFS = 6'h01;
	localparam logic [3:0] V1_VERSION = 4'h1;
	localparam logic [3:0] V2_VERSION = 4'h2;
	localparam logic [15:0] PTP_ETYPE = 16'h88F7;
	localparam logic [7:0] UDP_PROTO = 8'h11;
	localparam logic [15:0] PTP_EVENT_PORT = 16'h013F;
	localparam int unsigned EVENT_BIT = 3;
	localparam logic [3:0] V2_DELAY_REQ = 4'h1;
	localparam logic [3:0] V2_DELAY_RESP = 4'h9;
	localparam logic [7:0] V1_RESERVED_MIN = 8'h05;
	localparam logic [3:0] V2_EV_UNUSED_MIN = 4'h4;
	localparam logic [3:0] V2_GEN_UNUSED_MIN = 4'hE;
	localparam logic [5:0] LEN_MAX = 6'h3F;

	typedef enum logic [2:0] {
		SEL_L2_V2 = 3'b000,
		SEL_UDP_V1 = 3'b001,
		SEL_V2_BOTH = 3'b010,
		SEL_ALL = 3'b100,
		SEL_V2_EVENT = 3'b101
	} stamp_sel_t;

	// version 1 control codes
	typedef enum logic [2:0] {
		V1_SYNC = 3'b000,
		V1_DELAY_REQ = 3'b001,
		V1_FOLLOW_UP = 3'b010,
		V1_DELAY_RESP = 3'b011,
		V1_MGMT = 3'b100,
		V1_RSVD = 3'b111
	} v1_kind_t;

	typedef struct packed {
		logic enable;
		stamp_sel_t sel;
		logic [7:0] v1_control_match;
		logic [3:0] v2_message_kind_match;
	} rx_stamp_config_t;

	typedef struct packed {
		logic hit;
		logic steer_en;
		logic [1:0] queue;
	} filter_hit_t;

	typedef struct packed {
		logic [15:0] time_extension;
		logic [31:0] time_high_word;
		logic [31:0] time_low_word;
	} sys_time_t;
endpackage
`default_nettype wire

// >>> hw/sync_stamp_insert.sv
// one-step sync timestamp byte substitution on the transmit stream
`default_nettype none
module sync_stamp_insert (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic tx_valid_i,
	input wire logic tx_sop_i,
	input wire logic [7:0] tx_data_i,
	input wire logic one_step_i,
	input wire ptp_pkg::sys_time_t time_i,
	output logic tx_valid_o,
	output logic [7:0] tx_data_o
);
	logic [5:0] pos_ff;
	logic [5:0] nxt_pos;
	logic active_ff;
	logic nxt_active;
	ptp_pkg::sys_time_t snap_ff;
	logic [79:0] stamp_bytes;
	logic [5:0] cur_pos;
	logic in_field;
	logic [3:0] idx;
	logic [7:0] stamp_byte;
	logic [7:0] dout_ff;
	logic vout_ff;

	// time frozen at start of frame so all ten bytes are coherent
	assign cur_pos = tx_sop_i ? 6'h00 : pos_ff;
	assign nxt_pos = (tx_valid_i && cur_pos != ptp_pkg::LEN_MAX) ? cur_pos + 6'h01 : pos_ff;
	assign nxt_active = tx_valid_i && tx_sop_i ? one_step_i : active_ff;
	assign stamp_bytes = snap_ff;
	assign in_field = active_ff && cur_pos >= ptp_pkg::STAMP_OFS
		&& cur_pos < ptp_pkg::STAMP_OFS + 6'(ptp_pkg::STAMP_LEN);
	assign idx = 4'(cur_pos - ptp_pkg::STAMP_OFS);
	assign stamp_byte = stamp_bytes[8'(79 - 8 * idx) -: 8];

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pos_ff <= 6'h00;
			active_ff <= 1'b0;
			snap_ff <= '0;
			dout_ff <= 8'h00;
			vout_ff <= 1'b0;
		end else begin
			pos_ff <= nxt_pos;
			active_ff <= nxt_active;
			if (tx_valid_i && tx_sop_i)
				snap_ff <= time_i;
			vout_ff <= tx_valid_i;
			dout_ff <= (tx_valid_i && in_field && !tx_sop_i) ? stamp_byte : tx_data_i;
		end
	end
	assign tx_valid_o = vout_ff;
	assign tx_data_o = dout_ff;
endmodule
`default_nettype wire

// >>> hw/ptp_rx_classifier_stamp.sv
// receive precision-time classifier, queue steering and one-step sync stamp insertion
`default_nettype none
module ptp_rx_classifier_stamp (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire ptp_pkg::rx_stamp_config_t cfg_i,
	input wire logic rx_valid_i,
	input wire logic rx_sop_i,
	input wire logic rx_eop_i,
	input wire logic [7:0] rx_data_i,
	input wire ptp_pkg::filter_hit_t ethertype_filter_i,
	input wire ptp_pkg::filter_hit_t l4_protocol_filter_i,
	input wire logic port_match_filter_i,
	input wire logic [1:0] default_queue_i,
	input wire ptp_pkg::sys_time_t time_i,
	input wire logic tx_valid_i,
	input wire logic tx_sop_i,
	input wire logic [7:0] tx_data_i,
	input wire logic tx_one_step_i,
	output logic done_o,
	output logic stamp_o,
	output logic is_ptp_o,
	output logic is_event_o,
	output logic [3:0] v2_kind_o,
	output logic [2:0] v1_kind_o,
	output logic [1:0] queue_o,
	output ptp_pkg::sys_time_t stamp_time_o,
	output logic tx_valid_o,
	output logic [7:0] tx_data_o
);
	// ****************************************
	// decode helpers
	// ****************************************
	function automatic logic [2:0] v1_decode(input logic [7:0] c);
		v1_decode = (c >= ptp_pkg::V1_RESERVED_MIN) ? ptp_pkg::V1_RSVD : c[2:0];
	endfunction

	// ****************************************
	// byte capture over the frame
	// ****************************************
	logic [5:0] pos_ff;
	logic [5:0] cur_pos;
	logic [5:0] nxt_pos;
	logic in_frame_ff;
	logic [7:0] v2_byte_ff;
	logic [7:0] v1_ctrl_ff;
	logic [7:0] ver_byte_ff;
	logic long_ff;
	logic [7:0] v2_byte;
	logic [7:0] v1_ctrl;
	logic [7:0] ver_byte;
	logic long_enough;
	ptp_pkg::sys_time_t sof_time_ff;

	assign cur_pos = rx_sop_i ? 6'h00 : pos_ff;
	assign nxt_pos = (cur_pos != ptp_pkg::LEN_MAX) ? cur_pos + 6'h01 : cur_pos;
	assign v2_byte = (cur_pos == ptp_pkg::V2_TYPE_OFS) ? rx_data_i : v2_byte_ff;
	assign v1_ctrl = (cur_pos == ptp_pkg::V1_CTRL_OFS) ? rx_data_i : v1_ctrl_ff;
	assign ver_byte = (cur_pos == ptp_pkg::VERSION_OFS) ? rx_data_i : ver_byte_ff;
	// current byte counts toward length
	assign long_enough = long_ff || (cur_pos >= 6'(ptp_pkg::MIN_MSG_LEN - 1));

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pos_ff <= 6'h00;
			in_frame_ff <= 1'b0;
			v2_byte_ff <= 8'h00;
			v1_ctrl_ff <= 8'h00;
			ver_byte_ff <= 8'h00;
			long_ff <= 1'b0;
			sof_time_ff <= '0;
		end else if (rx_valid_i) begin
			pos_ff <= nxt_pos;
			in_frame_ff <= !rx_eop_i;
			v2_byte_ff <= v2_byte;
			v1_ctrl_ff <= v1_ctrl;
			ver_byte_ff <= ver_byte;
			long_ff <= rx_eop_i ? 1'b0 : long_enough;
			if (rx_sop_i)
				sof_time_ff <= time_i;
		end
	end

	// ****************************************
	// classification at end of frame
	// ****************************************
	logic [3:0] v2_kind;
	logic [2:0] v1_kind;
	logic v2_event;
	logic is_v1;
	logic is_v2;
	logic l2_ptp;
	logic udp_ptp;
	logic v2_match;
	logic take;
	logic l2_take;
	logic udp_take;
	logic end_now;

	assign end_now = rx_valid_i && rx_eop_i && (in_frame_ff || rx_sop_i);
	assign v2_kind = v2_byte[3:0];
	assign v1_kind = v1_decode(v1_ctrl);
	// header layout differs by version, so kind and control fields mean nothing across it
	assign is_v1 = ver_byte[3:0] == ptp_pkg::V1_VERSION;
	assign is_v2 = ver_byte[3:0] == ptp_pkg::V2_VERSION;
	assign v2_event = is_v2 && !v2_kind[ptp_pkg::EVENT_BIT];
	// transport is recognized by software-set filters
	assign l2_ptp = ethertype_filter_i.hit && long_enough;
	assign udp_ptp = l4_protocol_filter_i.hit && port_match_filter_i && long_enough;
	assign v2_match = is_v2 && (v2_kind == cfg_i.v2_message_kind_match
		|| v2_kind == ptp_pkg::V2_DELAY_REQ || v2_kind == ptp_pkg::V2_DELAY_RESP);

	always_comb begin
		case (cfg_i.sel)
			ptp_pkg::SEL_ALL: take = 1'b1;
			ptp_pkg::SEL_L2_V2: take = l2_ptp && v2_match;
			ptp_pkg::SEL_V2_BOTH: take = (l2_ptp || udp_ptp) && v2_match;
			ptp_pkg::SEL_V2_EVENT: take = (l2_ptp || udp_ptp) && v2_event;
			ptp_pkg::SEL_UDP_V1: take = udp_ptp && is_v1
				&& v1_ctrl == cfg_i.v1_control_match;
			default: take = 1'b0;
		endcase
	end

	// steering follows the selected condition; anything else keeps the normal queue
	assign l2_take = take && l2_ptp && ethertype_filter_i.steer_en;
	assign udp_take = take && udp_ptp && l4_protocol_filter_i.steer_en;

	logic done_ff;
	logic stamp_ff;
	logic is_ptp_ff;
	logic is_event_ff;
	logic [3:0] v2_kind_ff;
	logic [2:0] v1_kind_ff;
	logic [1:0] queue_ff;
	ptp_pkg::sys_time_t stamp_time_ff;
	logic [1:0] nxt_queue;

	assign nxt_queue = l2_take ? ethertype_filter_i.queue
		: udp_take ? l4_protocol_filter_i.queue
		: default_queue_i;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			done_ff <= 1'b0;
			stamp_ff <= 1'b0;
			is_ptp_ff <= 1'b0;
			is_event_ff <= 1'b0;
			v2_kind_ff <= 4'h0;
			v1_kind_ff <= 3'h0;
			queue_ff <= 2'h0;
			stamp_time_ff <= '0;
		end else begin
			done_ff <= end_now;
			if (end_now) begin
				stamp_ff <= cfg_i.enable && take;
				is_ptp_ff <= l2_ptp || udp_ptp;
				is_event_ff <= v2_event;
				v2_kind_ff <= v2_kind;
				v1_kind_ff <= v1_kind;
				queue_ff <= nxt_queue;
				stamp_time_ff <= sof_time_ff;
			end
		end
	end

	assign done_o = done_ff;
	assign stamp_o = stamp_ff;
	assign is_ptp_o = is_ptp_ff;
	assign is_event_o = is_event_ff;
	assign v2_kind_o = v2_kind_ff;
	assign v1_kind_o = v1_kind_ff;
	assign queue_o = queue_ff;
	assign stamp_time_o = stamp_time_ff;

	// ****************************************
	// transmit insertion
	// ****************************************
	sync_stamp_insert u_ins (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.tx_valid_i(tx_valid_i),
		.tx_sop_i(tx_sop_i),
		.tx_data_i(tx_data_i),
		.one_step_i(tx_one_step_i),
		.time_i(time_i),
		.tx_valid_o(tx_valid_o),
		.tx_data_o(tx_data_o)
	);

	// ****************************************
	// checks
	// ****************************************
	property p_no_stamp_disabled;
		@(posedge clk_i) disable iff (!rst_n_i) end_now && !cfg_i.enable |=> !stamp_o;
	endproperty
	a_no_stamp_disabled: assert property (p_no_stamp_disabled) else $error("stamp while off");

	property p_all;
		@(posedge clk_i) disable iff (!rst_n_i)
			end_now && cfg_i.enable && cfg_i.sel == ptp_pkg::SEL_ALL |=> stamp_o && done_o;
	endproperty
	a_all: assert property (p_all) else $error("select-all missed a stamp");

	property p_short;
		@(posedge clk_i) disable iff (!rst_n_i)
			end_now && !long_enough && cfg_i.sel != ptp_pkg::SEL_ALL |=> !stamp_o;
	endproperty
	a_short: assert property (p_short) else $error("short frame stamped");

	property p_event;
		@(posedge clk_i) disable iff (!rst_n_i)
			done_o && is_event_o |-> !v2_kind_o[ptp_pkg::EVENT_BIT];
	endproperty
	a_event: assert property (p_event) else $error("general kind flagged event");

	property p_v1_rsvd;
		@(posedge clk_i) disable iff (!rst_n_i)
			end_now && v1_ctrl >= ptp_pkg::V1_RESERVED_MIN |=> v1_kind_o == ptp_pkg::V1_RSVD;
	endproperty
	a_v1_rsvd: assert property (p_v1_rsvd) else $error("reserved control misdecoded");

	property p_l2_queue;
		@(posedge clk_i) disable iff (!rst_n_i)
			end_now && take && l2_ptp && ethertype_filter_i.steer_en
			|=> queue_o == $past(ethertype_filter_i.queue);
	endproperty
	a_l2_queue: assert property (p_l2_queue) else $error("l2 steering wrong");

	property p_udp_queue;
		@(posedge clk_i) disable iff (!rst_n_i)
			end_now && take && !l2_take && udp_ptp && l4_protocol_filter_i.steer_en
			|=> queue_o == $past(l4_protocol_filter_i.queue);
	endproperty
	a_udp_queue: assert property (p_udp_queue) else $error("udp steering wrong");

	property p_plain_queue;
		@(posedge clk_i) disable iff (!rst_n_i)
			end_now && !l2_take && !udp_take |=> queue_o == $past(default_queue_i);
	endproperty
	a_plain_queue: assert property (p_plain_queue) else $error("normal queue lost");

	property p_ins_first;
		@(posedge clk_i) disable iff (!rst_n_i)
			u_ins.active_ff && tx_valid_i && !tx_sop_i && u_ins.pos_ff == ptp_pkg::STAMP_OFS
			|=> tx_data_o == u_ins.snap_ff.time_extension[15:8];
	endproperty
	a_ins_first: assert property (p_ins_first) else $error("stamp first byte wrong");

	c_stamp: cover property (@(posedge clk_i) disable iff (!rst_n_i) done_o && stamp_o);
	c_udp: cover property (@(posedge clk_i) disable iff (!rst_n_i) end_now && udp_take);
	c_ins: cover property (@(posedge clk_i) disable iff (!rst_n_i) u_ins.in_field && tx_valid_i);
endmodule
`default_nettype wire

// >>> dv/ptp_peer_model.sv
// frame source standing in for the receive mac datapath and its filters
`default_nettype none
module ptp_peer_model (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic slow_i,
	input wire logic [63:0][7:0] frm_i,
	input wire logic [6:0] len_i,
	input wire logic [10:0] flt_i,
	output logic taken_o,
	output logic valid_o,
	output logic sop_o,
	output logic eop_o,
	output logic [7:0] data_o,
	output logic [10:0] flt_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [63:0][7:0] b;
	int n;
	logic slow;
	initial begin
		{taken_o, valid_o, sop_o, eop_o, data_o, flt_o} = '0;
		forever begin
			@(posedge clk_i);
			if (go_i !== 1'h1) begin
				// idle lines carry junk so a stale byte never passes for data
				{taken_o, valid_o, sop_o, eop_o} <= 4'h0;
				data_o <= ~data_o;
				flt_o <= ~flt_o;
			end else begin
				b = frm_i;
				n = len_i;
				slow = slow_i;
				flt_o <= flt_i;
				for (int k = 0; k < n; k++) begin
					if (k > 0) @(posedge clk_i);
					if (slow && k % 7 == 3) begin
						valid_o <= 1'h0;
						data_o <= ~data_o;
						@(posedge clk_i);
					end
					taken_o <= k == 0;
					valid_o <= 1'h1;
					sop_o <= k == 0;
					eop_o <= k == n - 1;
					data_o <= b[k];
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> dv/ptp_rx_classifier_stamp_tb.sv
// self-checking bench for the precision-time receive classifier and stamp inserter
`default_nettype none
module ptp_rx_classifier_stamp_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic st;
		logic [1:0] q;
		logic pc;
		logic ptp;
		logic v2;
		logic [3:0] kd;
		logic [2:0] v1k;
	} exp_t;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	ptp_pkg::rx_stamp_config_t cfg = '0;
	logic go = 1'h0;
	logic slow = 1'h0;
	logic [63:0][7:0] frm = '0;
	logic [6:0] len = 7'h24;
	logic [10:0] flt = '0;
	logic [10:0] flt_w;
	logic taken, rx_valid, rx_sop, rx_eop, done, stamp, is_ptp, is_ev, txv;
	logic [7:0] rx_data, txd;
	logic [3:0] v2k;
	logic [2:0] v1k;
	logic [1:0] q;
	ptp_pkg::sys_time_t tm = '0;
	ptp_pkg::sys_time_t st;
	logic tm_run = 1'h1;
	logic tx_valid = 1'h0;
	logic tx_sop = 1'h0;
	logic one_step = 1'h0;
	logic [7:0] tx_data = 8'h00;
	logic [15:0] lf = 16'h0060;
	int error_cnt = 0;
	int n_checks = 0;
	exp_t eq[$];
	exp_t me;
	ptp_pkg::sys_time_t tq[$];
	logic [7:0] bq[$];
	ptp_peer_model ptp_peer_model_inst (.clk_i(clk), .go_i(go), .slow_i(slow), .frm_i(frm),
		.len_i(len), .flt_i(flt), .taken_o(taken), .valid_o(rx_valid), .sop_o(rx_sop),
		.eop_o(rx_eop), .data_o(rx_data), .flt_o(flt_w));
	ptp_rx_classifier_stamp ptp_rx_classifier_stamp_inst (.clk_i(clk), .rst_n_i(rst_n),
		.cfg_i(cfg), .rx_valid_i(rx_valid), .rx_sop_i(rx_sop), .rx_eop_i(rx_eop),
		.rx_data_i(rx_data), .ethertype_filter_i(ptp_pkg::filter_hit_t'(flt_w[10:7])),
		.l4_protocol_filter_i(ptp_pkg::filter_hit_t'(flt_w[6:3])),
		.port_match_filter_i(flt_w[2]), .default_queue_i(flt_w[1:0]), .time_i(tm),
		.tx_valid_i(tx_valid), .tx_sop_i(tx_sop), .tx_data_i(tx_data),
		.tx_one_step_i(one_step), .done_o(done), .stamp_o(stamp), .is_ptp_o(is_ptp),
		.is_event_o(is_ev), .v2_kind_o(v2k), .v1_kind_o(v1k), .queue_o(q),
		.stamp_time_o(st), .tx_valid_o(txv), .tx_data_o(txd));
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		if (tm_run) tm <= ptp_pkg::sys_time_t'(tm + 80'h1);
		if (rx_valid === 1'h1 && rx_sop === 1'h1) tq.push_back(tm);
	end
	function automatic logic [7:0] rnd();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf[7:0];
	endfunction
	task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
		n_checks++;
		if (got !== ex) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic chkt(input string nm, input logic [79:0] ex, input logic [79:0] got);
		n_checks++;
		if (got !== ex) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// filter bundle: ethertype hit, l4 hit with port match, random steering and queues
	function automatic logic [10:0] mkf(input logic l2, input logic udp);
		logic [7:0] r;
		r = rnd();
		return {l2, r[2:0], udp, r[5:3], udp, r[7:6]};
	endfunction
	task automatic setcfg(input logic en, input logic [2:0] s, input logic [7:0] m1,
		input logic [3:0] m2);
		@(posedge clk);
		cfg <= {en, ptp_pkg::stamp_sel_t'(s), m1, m2};
		// let the new settings land before callers read them back
		@(posedge clk);
	endtask
	task automatic send(input logic v2, input logic [7:0] c, input int n, input logic [10:0] f);
		logic [63:0][7:0] b;
		exp_t e;
		logic l2, udp, m2, s;
		@(posedge clk);
		for (int k = 0; k < 64; k++) b[k] = rnd();
		if (v2) begin
			b[0][3:0] = c[3:0];
			b[1] = 8'h02;
		end else begin
			// version field is msb first, so byte 1 carries the 1
			b[1:0] = 16'h0100;
			b[32] = c;
		end
		l2 = f[10];
		udp = f[6] & f[2];
		m2 = v2 && (c[3:0] == cfg.v2_message_kind_match || c[3:0] == ptp_pkg::V2_DELAY_REQ
			|| c[3:0] == ptp_pkg::V2_DELAY_RESP);
		case (cfg.sel)
			ptp_pkg::SEL_ALL: s = 1'h1;
			ptp_pkg::SEL_L2_V2: s = l2 && m2;
			ptp_pkg::SEL_V2_BOTH: s = (l2 || udp) && m2;
			ptp_pkg::SEL_V2_EVENT: s = (l2 || udp) && v2 && !c[3];
			ptp_pkg::SEL_UDP_V1: s = udp && !v2 && c == cfg.v1_control_match;
			default: s = 1'h0;
		endcase
		e.st = s && cfg.enable && (n >= ptp_pkg::MIN_MSG_LEN || cfg.sel == ptp_pkg::SEL_ALL);
		// steering needs the selected condition on a recognized frame, not the stamp enable
		s = s && n >= ptp_pkg::MIN_MSG_LEN;
		e.q = (s && l2 && f[9]) ? f[8:7] : (s && udp && f[5]) ? f[4:3] : f[1:0];
		e.pc = l2 || udp;
		e.ptp = n >= ptp_pkg::MIN_MSG_LEN;
		e.v2 = v2;
		e.kd = c[3:0];
		e.v1k = (c <= 8'h04) ? c[2:0] : 3'h7;
		eq.push_back(e);
		frm <= b;
		len <= 7'(n);
		flt <= f;
		go <= 1'h1;
		slow <= rnd() > 8'hC0;
		for (int i = 0; i < 200; i++) begin
			@(posedge clk);
			if (taken === 1'h1) break;
		end
		chk("frame taken", 8'h01, 8'(taken));
	endtask
	task automatic quiet();
		@(posedge clk);
		go <= 1'h0;
		for (int i = 0; i < 200 && eq.size() != 0; i++) @(posedge clk);
		chk("frames left", 8'h00, 8'(eq.size()));
	endtask
	task automatic tx_frame(input logic os, input int n);
		logic [79:0] t;
		logic [7:0] b;
		for (int k = 0; k < n; k++) begin
			@(posedge clk);
			if (k == 0) t = tm;
			b = rnd();
			bq.push_back((os && k >= 34 && k < 44) ? t[79 - 8 * (k - 34) -: 8] : b);
			tx_valid <= 1'h1;
			tx_sop <= k == 0;
			one_step <= os;
			tx_data <= b;
		end
		@(posedge clk);
		tx_valid <= 1'h0;
		tx_sop <= 1'h0;
	endtask
	always @(negedge clk) begin
		if (done === 1'h1 && eq.size() == 0) chk("spurious done", 8'h00, 8'h01);
		if (done === 1'h1 && eq.size() != 0) begin
			me = eq.pop_front();
			chk("stamp", 8'(me.st), 8'(stamp));
			chk("queue", 8'(me.q), 8'(q));
			if (me.pc) chk("is_ptp", 8'(me.ptp), 8'(is_ptp));
			if (me.v2) chk("v2 kind", 8'(me.kd), 8'(v2k));
			if (me.v2) chk("event", 8'(!me.kd[3]), 8'(is_ev));
			if (!me.v2) chk("event", 8'h00, 8'(is_ev));
			if (!me.v2) chk("v1 kind", 8'(me.v1k), 8'(v1k));
			chkt("stamp time", tq.pop_front(), st);
		end
		if (txv === 1'h1 && bq.size() == 0) chk("tx extra", 8'h00, 8'h01);
		if (txv === 1'h1 && bq.size() != 0) chk("tx byte", bq.pop_front(), txd);
	end
	initial begin
		#500000;
		error_cnt++;
		report_and_stop();
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		@(negedge clk);
		chk("done after reset", 8'h00, 8'(done));
		for (int s = 0; s < 8; s++) begin
			setcfg(1'h1, 3'(s), rnd(), rnd());
			send(1'h1, 8'(cfg.v2_message_kind_match), 40, mkf(1'h1, 1'h0));
			send(1'h1, 8'h01, 36, mkf(1'h0, 1'h1));
			send(1'h1, 8'h09, 63, mkf(1'h1, 1'h1));
			send(1'h0, cfg.v1_control_match, 50, mkf(1'h0, 1'h1));
			send(1'h1, rnd(), 44, mkf(lf[3], lf[9]));
			send(1'h0, rnd(), 37, mkf(lf[4], lf[8]));
			quiet();
		end
		setcfg(1'h0, 3'h4, 8'h00, 4'h0);
		send(1'h1, 8'h01, 40, mkf(1'h1, 1'h0));
		send(1'h0, 8'h00, 40, mkf(1'h0, 1'h1));
		quiet();
		setcfg(1'h1, 3'h5, 8'h00, 4'h0);
		send(1'h1, 8'h00, 35, mkf(1'h1, 1'h0));
		send(1'h1, 8'h00, 36, mkf(1'h1, 1'h0));
		for (int k = 0; k < 16; k++) send(1'h1, 8'(k), 36, mkf(1'h0, 1'h1));
		quiet();
		setcfg(1'h1, 3'h1, 8'h03, 4'h0);
		for (int c = 0; c < 9; c++) begin
			send(1'h0, (c == 8) ? 8'hFF : 8'(c), 40, mkf(1'h0, 1'h1));
		end
		quiet();
		@(posedge clk);
		tm_run <= 1'h0;
		tx_frame(1'h1, 48);
		tx_frame(1'h0, 44);
		tx_frame(1'h1, 44);
		repeat (4) @(posedge clk);
		chk("tx left", 8'h00, 8'(bq.size()));
		report_and_stop();
	end
endmodule
`default_nettype wire
